// *** hw/dpsl_top.sv ***
`timescale 1ns/100ps
module dpsl_top #(
	parameter logic [31:0] KEY_PATTERN  = 32'h3A6C_95E1, // Arbitrary value
	parameter logic [15:0] ACQ_SEQUENCE = 16'hB4D2,
	parameter int          VOTE_MIN     = dpsl_pkg::VOTE_MIN_DEF
)(
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire logic                 nvLoad,
	input  wire logic [31:0]          nvLoadBits,
	input  wire logic [1:0]           nvLoadProt,
	input  wire dpsl_pkg::dpsl_cmd_s  cmdIn,
	input  wire logic [2:0]           blockPermit,
	input  wire logic                 fwJtagEnable,
	input  wire logic                 jtagTrstUsed,
	input  wire logic                 fwWireTraceEnable,
	input  wire logic                 fwTraceEnable,
	input  wire logic                 swdDisable,
	input  wire logic                 acqBitValid,
	input  wire logic                 acqBit,
	input  wire logic                 acqPairUsb,
	output dpsl_pkg::dpsl_resp_s      respOut,
	output dpsl_pkg::dpsl_ports_s     portsOut,
	output logic [3:0]                pinsUsed,
	output logic                      lockActive,
	output logic                      latchVote,
	output logic [1:0]                protLevel
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (VOTE_MIN < 1 || VOTE_MIN > dpsl_pkg::KEY_BITS)
	begin : g_bad_vote
		$error("VOTE_MIN out of range");
	end
	if (dpsl_pkg::WINDOW_CYCLES > (1 << dpsl_pkg::WIN_CNT_BITS))
	begin : g_bad_window
		$error("Key window too long for counter");
	end

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic voteMatch(input logic [31:0] bits);
		logic [5:0] hits;
		hits = 6'h00;
		for (int i = 0; i < dpsl_pkg::KEY_BITS; i++)
		begin
			hits = hits + {5'h00, ~(bits[i] ^ KEY_PATTERN[i])};
		end
		return hits >= 6'(VOTE_MIN);
	endfunction

	function automatic logic [3:0] pinCount(input dpsl_pkg::dpsl_ports_s p, input logic trst);
		logic [3:0] n;
		n = 4'h0;
		if (p.jtag)
		begin
			n = trst ? dpsl_pkg::PINS_JTAG_TRST : dpsl_pkg::PINS_JTAG_BASE;
		end
		if (p.swd)
		begin
			n = n + dpsl_pkg::PINS_SWD;
		end
		if (p.wireTrace)
		begin
			n = n + dpsl_pkg::PINS_WIRE_TRACE;
		end
		if (p.trace)
		begin
			n = n + dpsl_pkg::PINS_TRACE;
		end
		return n;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [31:0]           nvCells_ff;
	logic [31:0]           nxt_nvCells;
	logic [1:0]            protLevel_ff;
	logic [1:0]            nxt_protLevel;
	logic [31:0]           volatile_ff;
	logic [31:0]           nxt_volatile;
	logic                  lockSampled_ff;
	logic                  latchVote_ff;
	logic                  nxt_latchVote;
	dpsl_pkg::dpsl_resp_s  resp_ff;
	dpsl_pkg::dpsl_resp_s  nxt_resp;
	dpsl_pkg::dpsl_ports_s ports_ff;
	dpsl_pkg::dpsl_ports_s nxt_ports;
	logic [3:0]            pins_ff;
	logic [3:0]            nxt_pins;
	dpsl_pkg::dpsl_acq_e   acqState_ff;
	dpsl_pkg::dpsl_acq_e   nxt_acqState;
	logic [9:0]            winCnt_ff;
	logic [9:0]            nxt_winCnt;
	logic [15:0]           acqShift_ff;
	logic [15:0]           nxt_acqShift;
	logic                  latchLive;
	logic                  hostAccess;
	logic                  cmdGo;
	logic                  keyWriteOk;
	logic                  devErase;
	logic [15:0]           seqNext;
	logic                  acqHit;

	assign latchLive  = voteMatch(nvCells_ff);
	assign hostAccess = !lockSampled_ff && (ports_ff.jtag || ports_ff.swd);
	assign cmdGo      = rst_b && cmdIn.valid && hostAccess;
	assign keyWriteOk = (protLevel_ff == dpsl_pkg::PROT_NONE) && !latchLive;
	assign devErase   = cmdGo && (cmdIn.op == dpsl_pkg::OP_ERASE) && !cmdIn.blockScope;
	assign seqNext    = {acqShift_ff[14:0], acqBit};
	assign acqHit     = (acqState_ff == dpsl_pkg::ACQ_OPEN) && acqBitValid
		&& (seqNext == ACQ_SEQUENCE) && !lockSampled_ff;

	// ----------------------------------------
	// Nonvolatile cells and protection
	// ----------------------------------------
	always_comb
	begin
		nxt_nvCells   = nvCells_ff;
		nxt_protLevel = protLevel_ff;
		if (nvLoad)
		begin
			nxt_nvCells   = nvLoadBits;
			nxt_protLevel = nvLoadProt;
		end
		else if (cmdGo)
		begin
			case (cmdIn.op)
				dpsl_pkg::OP_ERASE:
				begin
					if (!cmdIn.blockScope)
					begin
						nxt_protLevel = dpsl_pkg::PROT_NONE;
					end
				end
				dpsl_pkg::OP_SET_PROT:
				begin
					if (cmdIn.data[1:0] >= protLevel_ff)
					begin
						nxt_protLevel = cmdIn.data[1:0];
					end
				end
				dpsl_pkg::OP_KEY_COMMIT:
				begin
					if (keyWriteOk)
					begin
						nxt_nvCells = volatile_ff;
					end
				end
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		nvCells_ff   <= nxt_nvCells;
		protLevel_ff <= nxt_protLevel;
	end

	// ----------------------------------------
	// Commands, ports, acquisition
	// ----------------------------------------
	always_comb
	begin
		nxt_volatile  = volatile_ff;
		nxt_resp      = '0;
		nxt_latchVote = latchLive;
		if (cmdIn.valid)
		begin
			nxt_resp.done = 1'b1;
		end
		if (cmdGo)
		begin
			case (cmdIn.op)
				dpsl_pkg::OP_ERASE:
				begin
					nxt_resp.granted = cmdIn.blockScope ? blockPermit[0] : 1'b1;
				end
				dpsl_pkg::OP_PROGRAM:
				begin
					nxt_resp.granted = cmdIn.blockScope ? blockPermit[1] : 1'b1;
				end
				dpsl_pkg::OP_VERIFY:
				begin
					nxt_resp.granted = cmdIn.blockScope ? blockPermit[2] : 1'b1;
				end
				dpsl_pkg::OP_SET_PROT:
				begin
					nxt_resp.granted = cmdIn.data[1:0] >= protLevel_ff;
				end
				dpsl_pkg::OP_KEY_LOAD:
				begin
					nxt_resp.granted = keyWriteOk;
					if (keyWriteOk)
					begin
						nxt_volatile = cmdIn.data;
					end
				end
				dpsl_pkg::OP_KEY_COMMIT:
				begin
					nxt_resp.granted = keyWriteOk;
				end
				dpsl_pkg::OP_LATCH_READ:
				begin
					nxt_resp.granted = ports_ff.swd;
					nxt_resp.data    = ports_ff.swd ? nvCells_ff : 32'h0000_0000;
				end
				default:
				begin
				end
			endcase
		end

		nxt_acqShift = acqBitValid ? seqNext : acqShift_ff;
		nxt_winCnt   = winCnt_ff;
		nxt_acqState = acqState_ff;
		case (acqState_ff)
			dpsl_pkg::ACQ_OPEN:
			begin
				if (winCnt_ff == 10'(dpsl_pkg::WINDOW_CYCLES - 1))
				begin
					nxt_acqState = dpsl_pkg::ACQ_CLOSED;
				end
				else
				begin
					nxt_winCnt = winCnt_ff + 10'h001;
				end
			end
			default:
			begin
				nxt_acqState = dpsl_pkg::ACQ_CLOSED;
			end
		endcase

		nxt_ports          = ports_ff;
		nxt_ports.swd      = acqHit || (ports_ff.swd && !swdDisable);
		nxt_ports.swdOnUsb = acqHit ? acqPairUsb : ports_ff.swdOnUsb;
		nxt_ports.jtag     = fwJtagEnable && !(nxt_ports.swd && !nxt_ports.swdOnUsb);
		nxt_ports.wireTrace = fwWireTraceEnable && !nxt_ports.jtag;
		nxt_ports.trace    = fwTraceEnable;
		if (lockSampled_ff)
		begin
			nxt_ports = '0;
		end
		nxt_pins = pinCount(nxt_ports, jtagTrstUsed);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			lockSampled_ff <= latchLive;
			latchVote_ff   <= 1'b0;
			volatile_ff    <= dpsl_pkg::VOLATILE_RST;
			resp_ff        <= '0;
			ports_ff       <= '0;
			pins_ff        <= 4'h0;
			acqState_ff    <= dpsl_pkg::ACQ_OPEN;
			winCnt_ff      <= 10'h000;
			acqShift_ff    <= 16'h0000;
		end
		else
		begin
			latchVote_ff <= nxt_latchVote;
			volatile_ff  <= nxt_volatile;
			resp_ff      <= nxt_resp;
			ports_ff     <= nxt_ports;
			pins_ff      <= nxt_pins;
			acqState_ff  <= nxt_acqState;
			winCnt_ff    <= nxt_winCnt;
			acqShift_ff  <= nxt_acqShift;
		end
	end

	assign respOut    = resp_ff;
	assign portsOut   = ports_ff;
	assign pinsUsed   = pins_ff;
	assign lockActive = lockSampled_ff;
	assign latchVote  = latchVote_ff;
	assign protLevel  = protLevel_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_keyLoadBlocked;
		cmdIn.valid && cmdIn.op == dpsl_pkg::OP_KEY_LOAD && protLevel_ff != dpsl_pkg::PROT_NONE;
	endsequence
	sequence s_refused;
		resp_ff.done && !resp_ff.granted;
	endsequence
	sequence s_commitOk;
		cmdGo && cmdIn.op == dpsl_pkg::OP_KEY_COMMIT && keyWriteOk && !nvLoad;
	endsequence

	a_lock_ports_off:   assert property (lockSampled_ff |-> ##1 ports_ff == '0)
		else $error("Port open while locked");
	a_lock_held:        assert property ($past(rst_b) |-> $stable(lockSampled_ff))
		else $error("Lock changed between resets");
	a_vote_sampled:     assert property ($rose(rst_b) |-> lockSampled_ff == voteMatch($past(nvCells_ff)))
		else $error("Lock does not follow vote");
	a_key_load_gate:    assert property (s_keyLoadBlocked |=> s_refused)
		else $error("Key load accepted under protection");
	a_latch_frozen:     assert property (latchLive && !nvLoad |=> $stable(nvCells_ff))
		else $error("Matching latch was altered");
	a_prot_no_lower:    assert property ($past(!nvLoad) && protLevel_ff < $past(protLevel_ff)
		|-> $past(devErase))
		else $error("Protection lowered without erase");
	a_commit_access:    assert property (s_commitOk |=> nvCells_ff == $past(volatile_ff)
		##1 !lockSampled_ff)
		else $error("Commit failed or locked early");
	a_wtrace_jtag:      assert property (!(ports_ff.wireTrace && ports_ff.jtag))
		else $error("Single-wire trace with JTAG");
	a_pin_count:        assert property (pins_ff == pinCount(ports_ff, $past(jtagTrstUsed)))
		else $error("Pin count mismatch");
	a_window_closed:    assert property (acqState_ff == dpsl_pkg::ACQ_CLOSED |=> !$rose(ports_ff.swd))
		else $error("SWD acquired after window");
	a_read_swd_only:    assert property (cmdGo && cmdIn.op == dpsl_pkg::OP_LATCH_READ && !ports_ff.swd
		|=> s_refused)
		else $error("Latch read without SWD");

endmodule

// *** shared/dpsl_pkg.sv ***
package dpsl_pkg;

	// ----------------------------------------
	// Latch and vote
	// ----------------------------------------
	localparam int          KEY_BITS     = 32;
	localparam int          VOTE_MIN_DEF = 28;
	localparam int          PROT_BITS    = 2;
	localparam logic [1:0]  PROT_NONE    = 2'h0;
	localparam logic [31:0] VOLATILE_RST = 32'h0000_0000;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int KEY_WINDOW_NS = 8000;
	localparam int WINDOW_CYCLES = KEY_WINDOW_NS / CLK_PERIOD_NS;
	localparam int WIN_CNT_BITS  = 10;
	localparam int ACQ_SEQ_BITS  = 16;

	// ----------------------------------------
	// Pins claimed per interface
	// ----------------------------------------
	localparam logic [3:0] PINS_JTAG_BASE  = 4'h4;
	localparam logic [3:0] PINS_JTAG_TRST  = 4'h5;
	localparam logic [3:0] PINS_SWD        = 4'h2;
	localparam logic [3:0] PINS_WIRE_TRACE = 4'h1;
	localparam logic [3:0] PINS_TRACE      = 4'h5;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_NOP        = 3'h0,
		OP_ERASE      = 3'h1,
		OP_PROGRAM    = 3'h2,
		OP_VERIFY     = 3'h3,
		OP_SET_PROT   = 3'h4,
		OP_KEY_LOAD   = 3'h5,
		OP_KEY_COMMIT = 3'h6,
		OP_LATCH_READ = 3'h7
	} dpsl_op_e;

	typedef enum logic [0:0] {
		ACQ_OPEN   = 1'h0,
		ACQ_CLOSED = 1'h1
	} dpsl_acq_e;

	typedef struct packed {
		logic        valid;
		dpsl_op_e    op;
		logic        blockScope;
		logic [31:0] data;
	} dpsl_cmd_s;

	typedef struct packed {
		logic        done;
		logic        granted;
		logic [31:0] data;
	} dpsl_resp_s;

	typedef struct packed {
		logic jtag;
		logic swd;
		logic swdOnUsb;
		logic wireTrace;
		logic trace;
	} dpsl_ports_s;

endpackage

// *** tb/dpsl_probe.sv ***
`timescale 1ns/100ps
module dpsl_probe #(
	parameter logic [15:0] SEQ = 16'hB4D2
)(
	input  wire logic clk,
	input  wire logic start,
	input  wire logic pairUsb,
	output logic      acqBitValid,
	output logic      acqBit,
	output logic      acqPairUsb
);
	// ----------------------------------------
	// Enabling sequence, MSB first
	// ----------------------------------------
	int cnt = 16;
	initial
	begin
		acqBitValid = 1'b0;
		acqBit      = 1'b0;
		acqPairUsb  = 1'b0;
	end
	always @(posedge clk)
	begin
		if (start)
		begin
			cnt = 0;
			acqPairUsb <= pairUsb;
		end
		if (cnt < 16)
		begin
			acqBitValid <= 1'b1;
			acqBit      <= SEQ[15 - cnt];
			cnt = cnt + 1;
		end
		else
		begin
			acqBitValid <= 1'b0;
			acqBit      <= ~acqBit;
		end
	end
endmodule

// *** tb/dpsl_top_tb.sv ***
`timescale 1ns/100ps
module dpsl_top_tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [31:0] KEY = 32'h3A6C_95E1; // Arbitrary value
	localparam logic [15:0] SEQ = 16'hB4D2;
	logic                  clk = 1'b0;
	logic                  rst_b, nvLoad, swdDisable, start, pairUsb;
	logic                  fwJtagEnable, jtagTrstUsed, fwWireTraceEnable, fwTraceEnable;
	logic                  acqBitValid, acqBit, acqPairUsb, lockActive, latchVote;
	logic [31:0]           nvLoadBits;
	logic [1:0]            nvLoadProt, protLevel;
	logic [2:0]            blockPermit;
	logic [3:0]            pinsUsed;
	logic [33:0]           e;
	logic [33:0]           expQ[$];
	dpsl_pkg::dpsl_cmd_s   cmdIn;
	dpsl_pkg::dpsl_resp_s  respOut;
	dpsl_pkg::dpsl_ports_s portsOut;
	int                    mismatches = 0;
	int                    samplesChecked = 0;

	always #4 clk = ~clk;

	dpsl_top #(.KEY_PATTERN(KEY), .ACQ_SEQUENCE(SEQ)) i_dpsl_top (.clk(clk), .rst_b(rst_b),
		.nvLoad(nvLoad), .nvLoadBits(nvLoadBits), .nvLoadProt(nvLoadProt), .cmdIn(cmdIn),
		.blockPermit(blockPermit), .fwJtagEnable(fwJtagEnable), .jtagTrstUsed(jtagTrstUsed),
		.fwWireTraceEnable(fwWireTraceEnable), .fwTraceEnable(fwTraceEnable),
		.swdDisable(swdDisable),
		.acqBitValid(acqBitValid), .acqBit(acqBit), .acqPairUsb(acqPairUsb),
		.respOut(respOut), .portsOut(portsOut), .pinsUsed(pinsUsed),
		.lockActive(lockActive), .latchVote(latchVote), .protLevel(protLevel));

	dpsl_probe #(.SEQ(SEQ)) i_dpsl_probe (.clk(clk), .start(start), .pairUsb(pairUsb),
		.acqBitValid(acqBitValid), .acqBit(acqBit), .acqPairUsb(acqPairUsb));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chkVal(logic [31:0] a, logic [31:0] x, string m);
		samplesChecked++;
		if (a !== x)
		begin
			mismatches++;
			$display("BAD %0t %s got %h want %h", $time, m, a, x);
		end
	endtask

	task automatic wt(int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic cmd(dpsl_pkg::dpsl_op_e op, logic blk, logic [31:0] d, logic g);
		@(posedge clk);
		cmdIn <= '{1'b1, op, blk, d};
		expQ.push_back({op == dpsl_pkg::OP_LATCH_READ, g, d});
		@(posedge clk);
		cmdIn <= '0;
	endtask

	task automatic acquire(logic usb);
		@(posedge clk);
		pairUsb <= usb;
		start   <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		wt(20);
	endtask

	task automatic pulse(logic [31:0] bits);
		@(posedge clk);
		nvLoad     <= 1'b1;
		nvLoadBits <= bits;
		@(posedge clk);
		nvLoad <= 1'b0;
		wt(3);
	endtask

	task automatic rst();
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		wt(2);
	endtask

	task automatic summarize();
		$display("Checks %0d, mismatches %0d", samplesChecked, mismatches);
		if (mismatches == 0 && samplesChecked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------
	// Response watcher
	// ----------------------------------------
	always @(negedge clk)
	begin
		if (respOut.done === 1'b1)
		begin
			chkVal(expQ.size() != 0, 1, "stray response");
			e = expQ.pop_front();
			chkVal(respOut.granted, e[32], "grant");
			if (e[33])
				chkVal(respOut.data, e[31:0], "read data");
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(32'h2086));
		rst_b = 1'b0;
		nvLoad = 1'b1;
		nvLoadBits = ~KEY;
		nvLoadProt = dpsl_pkg::PROT_NONE;
		cmdIn = '0;
		blockPermit = 3'h0;
		fwJtagEnable = 1'b1;
		jtagTrstUsed = 1'b0;
		fwWireTraceEnable = 1'b1;
		fwTraceEnable = 1'b1;
		swdDisable = 1'b0;
		start = 1'b0;
		pairUsb = 1'b0;
		rst();
		nvLoad <= 1'b0;
		chkVal(lockActive, 0, "open part");
		chkVal({portsOut, pinsUsed}, {5'b10001, 4'h9}, "jtag and trace");
		jtagTrstUsed <= 1'b1;
		wt(2);
		chkVal(pinsUsed, 4'hA, "jtag with reset pin");
		jtagTrstUsed <= 1'b0;
		for (int i = 0; i < 3; i++)
			cmd(dpsl_pkg::OP_PROGRAM, 1'b0, $urandom, 1'b1);
		cmd(dpsl_pkg::OP_ERASE, 1'b0, 32'h0, 1'b1);
		cmd(dpsl_pkg::OP_VERIFY, 1'b0, 32'h0, 1'b1);
		for (int i = 0; i < 3; i++)
		begin
			blockPermit <= ~(3'h1 << i);
			cmd(dpsl_pkg::dpsl_op_e'(i + 1), 1'b1, 32'h0, 1'b0);
			blockPermit <= 3'h1 << i;
			cmd(dpsl_pkg::dpsl_op_e'(i + 1), 1'b1, 32'h0, 1'b1);
		end
		cmd(dpsl_pkg::OP_SET_PROT, 1'b0, 32'h2, 1'b1);
		cmd(dpsl_pkg::OP_SET_PROT, 1'b0, 32'h1, 1'b0);
		cmd(dpsl_pkg::OP_KEY_LOAD, 1'b0, KEY, 1'b0);
		wt(2);
		chkVal(protLevel, 2'h2, "protection kept");
		cmd(dpsl_pkg::OP_ERASE, 1'b0, 32'h0, 1'b1);
		wt(2);
		chkVal(protLevel, dpsl_pkg::PROT_NONE, "erase clears");
		cmd(dpsl_pkg::OP_LATCH_READ, 1'b0, 32'h0000_0000, 1'b0);
		fwTraceEnable <= 1'b0;
		acquire(1'b0);
		chkVal({portsOut, pinsUsed}, {5'b01010, 4'h3}, "swd on jtag pair");
		cmd(dpsl_pkg::OP_LATCH_READ, 1'b0, ~KEY, 1'b1);
		fwJtagEnable <= 1'b0;
		@(posedge clk);
		swdDisable <= 1'b1;
		@(posedge clk);
		swdDisable <= 1'b0;
		wt(2);
		chkVal(portsOut.swd, 0, "swd disabled");
		acquire(1'b1);
		chkVal({portsOut, pinsUsed}, {5'b01110, 4'h3}, "swd reacquired");
		cmd(dpsl_pkg::OP_KEY_LOAD, 1'b0, KEY, 1'b1);
		cmd(dpsl_pkg::OP_KEY_COMMIT, 1'b0, 32'h0, 1'b1);
		wt(3);
		chkVal({lockActive, latchVote}, 2'b01, "key stored, still open");
		cmd(dpsl_pkg::OP_LATCH_READ, 1'b0, KEY, 1'b1);
		cmd(dpsl_pkg::OP_KEY_LOAD, 1'b0, ~KEY, 1'b0);
		cmd(dpsl_pkg::OP_KEY_COMMIT, 1'b0, 32'h0, 1'b0);
		repeat (1000) @(posedge clk);
		swdDisable <= 1'b1;
		@(posedge clk);
		swdDisable <= 1'b0;
		acquire(1'b0);
		chkVal(portsOut.swd, 0, "window closed");
		rst();
		chkVal(lockActive, 1, "locked");
		chkVal({portsOut, pinsUsed}, 9'h0, "ports closed");
		cmd(dpsl_pkg::OP_VERIFY, 1'b0, 32'h0, 1'b0);
		acquire(1'b0);
		chkVal(portsOut.swd, 0, "no acquire when locked");
		pulse(KEY ^ 32'h0000_000F);
		chkVal(latchVote, 1, "28 bits match");
		pulse(KEY ^ 32'h0000_001F);
		chkVal({lockActive, latchVote}, 2'b10, "27 bits, lock held");
		rst();
		chkVal(lockActive, 0, "unlocked after reset");
		wt(3);
		chkVal(expQ.size(), 0, "missing responses");
		summarize();
	end
endmodule
